// [hdl/scf_defines.vh]
`ifndef SCF_DEFINES_VH
`define SCF_DEFINES_VH
// register byte addresses
`define SCF_ADDR_CTRL     4'h0
`define SCF_ADDR_STATUS   4'h4
`define SCF_ADDR_MODE     4'h8
`define SCF_ADDR_IRQ_STAT 4'hC
`define SCF_ADDR_IRQ_MASK 5'h10
`define SCF_ADDR_TXDATA   5'h14
`define SCF_ADDR_RXDATA   5'h18
// control bit positions
`define SCF_CTRL_TIE  7
`define SCF_CTRL_RIE  6
`define SCF_CTRL_TE   5
`define SCF_CTRL_RE   4
`define SCF_CTRL_ADDR_WAIT_IRQ_EN 3
`define SCF_CTRL_TX_DONE_IRQ_EN 2
// status bit positions
`define SCF_ST_TX_HOLDING_EMPTY 7
`define SCF_ST_RX_HOLDING_FULL 6
`define SCF_ST_PER  3
`define SCF_ST_TX_DONE_FLAG 2
`define SCF_ST_MPB  1
// mode register fields
`define SCF_MODE_SYNC 7
`define SCF_MODE_PEN  5
`define SCF_MODE_ODD  4
`define SCF_MODE_MP   2
// reset values
`define SCF_CTRL_RST   8'h00
`define SCF_STATUS_RST 8'h84
`define SCF_MODE_RST   8'h00
// interrupt status bits
`define SCF_IRQ_TXE  0
`define SCF_IRQ_TXD  1
`define SCF_IRQ_RXF  2
`define SCF_IRQ_PER  3
`define SCF_IRQ_W    4
// baud prescale taps
`define SCF_DIV4  2'h3
`define SCF_DIV16 4'hF
`define SCF_DIV64 6'h3F
`endif

// [hdl/scf_serial_ctrl_status_flags.v]
`timescale 1ns/10ps
// Contract
// - the control register clears to zero on reset, standby and module stop.
// - a build option keeps the control register through soft standby and module stop.
// - the cpu can read and write the control register at any time.
// - a holding-to-shift move sets holding-empty and, with bit 7 set, the empty request.
// - the empty request drops on read-1-then-write-0 of holding-empty or on enable clear.
// - async reception with parity sets the parity error flag on mismatch.
// - the parity error flag clears only by writing 0 after reading 1, resets to 0.
// - clearing receive enable leaves the parity error flag as it is.
// - on parity error the byte still loads the rx holding register without setting full.
// - while parity error is set reception stops, and in sync mode transmission too.
// - the transmit-end flag is read-only and resets to 1.
// - transmit-end sets when transmit is off or holding is empty at the last bit.
// - transmit-end clears on the holding-empty clear or on a dma write of the data.
// - the multiprocessor bit stores the last received address bit, reset 0.
// - clearing receive enable in mp format keeps the multiprocessor bit.
// - baud source select 00,01,10,11 gives clock, /4, /16, /64.
`include "scf_defines.vh"
module scf_serial_ctrl_status_flags #(
  parameter KEEP_IN_STANDBY = 1'b0
) (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  input  wire        hwStandby,
  input  wire        swStandby,
  input  wire        moduleStop,
  input  wire        txLoad,
  input  wire        txLastBit,
  input  wire        rxDone,
  input  wire [7:0]  rxByte,
  input  wire        rxParityBit,
  input  wire        rxMpBit,
  input  wire        dmaTxWrite,
  input  wire [7:0]  dmaTxData,
  output wire        txEmptyIrq,
  output wire        rxRun,
  output wire        txRun,
  output wire        baudTick,
  output wire [7:0]  txHoldingReg,
  output wire        irq
);
  reg [7:0] ctrlQ;
  reg [7:0] modeQ;
  reg [7:0] txDataQ;
  reg [7:0] rxDataQ;
  reg       tdreQ;
  reg       rdrfQ;
  reg       perQ;
  reg       tendQ;
  reg       mpbQ;
  reg [2:0] readOneQ;
  reg [`SCF_IRQ_W-1:0] irqStatQ;
  reg [`SCF_IRQ_W-1:0] irqMaskQ;
  reg [5:0] preQ;
  reg       aphWrQ;
  reg       aphRdQ;
  reg [4:0] aphAddrQ;
  wire      aphValid;
  wire      wrCtrl;
  wire      wrStat;
  wire      wrMode;
  wire      wrIrqS;
  wire      wrIrqM;
  wire      wrTx;
  wire      rdStat;
  wire [7:0] statusVal;
  wire      parityBad;
  wire      tdreClr;
  wire      perClr;
  wire      rdrfClr;
  wire      ctrlClear;
  wire [`SCF_IRQ_W-1:0] irqEvents;

  // ahb-lite slave: zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign aphValid  = hsel & hready & htrans[1];

  // latch address phase for the data phase
  always @(posedge sys_clk) begin
    if (rst) begin
      aphWrQ   <= 1'b0;
      aphRdQ   <= 1'b0;
      aphAddrQ <= 5'h00;
    end else begin
      aphWrQ   <= aphValid & hwrite;
      aphRdQ   <= aphValid & ~hwrite;
      aphAddrQ <= haddr[4:0];
    end
  end

  assign wrCtrl = aphWrQ & (aphAddrQ == {1'b0, `SCF_ADDR_CTRL});
  assign wrStat = aphWrQ & (aphAddrQ == {1'b0, `SCF_ADDR_STATUS});
  assign wrMode = aphWrQ & (aphAddrQ == {1'b0, `SCF_ADDR_MODE});
  assign wrIrqS = aphWrQ & (aphAddrQ == {1'b0, `SCF_ADDR_IRQ_STAT});
  assign wrIrqM = aphWrQ & (aphAddrQ == `SCF_ADDR_IRQ_MASK);
  assign wrTx   = aphWrQ & (aphAddrQ == `SCF_ADDR_TXDATA);
  assign rdStat = aphValid & ~hwrite & (haddr[4:0] == {1'b0, `SCF_ADDR_STATUS});

  assign statusVal = {tdreQ, rdrfQ, 2'b00, perQ, tendQ, mpbQ, 1'b0};

  // read data: sampled in address phase, presented in data phase
  always @(posedge sys_clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (aphValid & ~hwrite) begin
      case (haddr[4:0])
        {1'b0, `SCF_ADDR_CTRL}:     hrdata <= {24'h000000, ctrlQ};
        {1'b0, `SCF_ADDR_STATUS}:   hrdata <= {24'h000000, statusVal};
        {1'b0, `SCF_ADDR_MODE}:     hrdata <= {24'h000000, modeQ};
        {1'b0, `SCF_ADDR_IRQ_STAT}: hrdata <= {28'h0000000, irqStatQ};
        `SCF_ADDR_IRQ_MASK:         hrdata <= {28'h0000000, irqMaskQ};
        `SCF_ADDR_TXDATA:           hrdata <= {24'h000000, txDataQ};
        `SCF_ADDR_RXDATA:           hrdata <= {24'h000000, rxDataQ};
        default:                    hrdata <= 32'h00000000;
      endcase
    end
  end

  // control clears on hardware standby, and on soft standby/stop unless the keep option is built
  assign ctrlClear = hwStandby |
                     (~KEEP_IN_STANDBY & (swStandby | moduleStop));

  // control and mode registers
  always @(posedge sys_clk) begin
    if (rst | ctrlClear) begin
      ctrlQ <= `SCF_CTRL_RST;
    end else if (wrCtrl) begin
      ctrlQ <= hwdata[7:0];
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      modeQ <= `SCF_MODE_RST;
    end else if (wrMode) begin
      modeQ <= hwdata[7:0];
    end
  end

  // clear requests need a prior read of 1 and a written 0
  assign tdreClr = wrStat & readOneQ[0] & ~hwdata[`SCF_ST_TX_HOLDING_EMPTY];
  assign rdrfClr = wrStat & readOneQ[1] & ~hwdata[`SCF_ST_RX_HOLDING_FULL];
  assign perClr  = wrStat & readOneQ[2] & ~hwdata[`SCF_ST_PER];

  // read-as-one records, dropped once the write is seen
  always @(posedge sys_clk) begin
    if (rst) begin
      readOneQ <= 3'b000;
    end else if (rdStat) begin
      readOneQ <= {perQ, rdrfQ, tdreQ};
    end else if (wrStat) begin
      readOneQ <= 3'b000;
    end
  end

  // parity over data plus parity bit versus odd/even select
  assign parityBad = modeQ[`SCF_MODE_PEN] & ~modeQ[`SCF_MODE_SYNC] &
                     ((^rxByte ^ rxParityBit) != modeQ[`SCF_MODE_ODD]);

  // transmit data and holding-empty flag
  always @(posedge sys_clk) begin
    if (rst) begin
      txDataQ <= 8'h00;
      tdreQ   <= 1'b1;
    end else begin
      if (wrTx) begin
        txDataQ <= hwdata[7:0];
      end else if (dmaTxWrite) begin
        txDataQ <= dmaTxData;
      end
      if (txLoad) begin
        tdreQ <= 1'b1;
      end else if (tdreClr | dmaTxWrite) begin
        tdreQ <= 1'b0;
      end
    end
  end

  // transmit-end flag, hardware only
  always @(posedge sys_clk) begin
    if (rst) begin
      tendQ <= 1'b1;
    end else if (~ctrlQ[`SCF_CTRL_TE] | (txLastBit & tdreQ)) begin
      tendQ <= 1'b1;
    end else if (tdreClr | dmaTxWrite) begin
      tendQ <= 1'b0;
    end
  end

  // receive data, full, parity error and multiprocessor bit
  always @(posedge sys_clk) begin
    if (rst) begin
      rxDataQ <= 8'h00;
      rdrfQ   <= 1'b0;
      perQ    <= 1'b0;
      mpbQ    <= 1'b0;
    end else begin
      if (rxDone & rxRun) begin
        rxDataQ <= rxByte;
      end
      if (rxDone & rxRun & ~parityBad) begin
        rdrfQ <= 1'b1;
      end else if (rdrfClr) begin
        rdrfQ <= 1'b0;
      end
      // rx enable clear does not touch per or mpb
      if (rxDone & rxRun & parityBad) begin
        perQ <= 1'b1;
      end else if (perClr) begin
        perQ <= 1'b0;
      end
      if (rxDone & rxRun & modeQ[`SCF_MODE_MP] & ~modeQ[`SCF_MODE_SYNC]) begin
        mpbQ <= rxMpBit;
      end
    end
  end

  // receiver runs only while enabled and no parity error stands; transmitter stops on parity error only in sync mode
  assign rxRun = ctrlQ[`SCF_CTRL_RE] & ~perQ;
  assign txRun = ctrlQ[`SCF_CTRL_TE] &
                 ~(perQ & modeQ[`SCF_MODE_SYNC]);

  // empty request level follows flag and enable
  assign txEmptyIrq = tdreQ & ctrlQ[`SCF_CTRL_TIE];
  assign txHoldingReg = txDataQ;

  // baud source prescaler
  always @(posedge sys_clk) begin
    if (rst) begin
      preQ <= 6'h00;
    end else begin
      preQ <= preQ + 6'h01;
    end
  end

  assign baudTick = (modeQ[1:0] == 2'b00) ? 1'b1 :
                    (modeQ[1:0] == 2'b01) ? (preQ[1:0] == `SCF_DIV4) :
                    (modeQ[1:0] == 2'b10) ? (preQ[3:0] == `SCF_DIV16) :
                    (preQ == `SCF_DIV64);

  // sticky interrupt status, write one to clear, set wins
  assign irqEvents[`SCF_IRQ_TXE] = txLoad & ctrlQ[`SCF_CTRL_TIE];
  assign irqEvents[`SCF_IRQ_TXD] = txLastBit & tdreQ & ctrlQ[`SCF_CTRL_TX_DONE_IRQ_EN];
  assign irqEvents[`SCF_IRQ_RXF] = rxDone & rxRun & ~parityBad &
                                   ctrlQ[`SCF_CTRL_RIE];
  assign irqEvents[`SCF_IRQ_PER] = rxDone & rxRun & parityBad &
                                   ctrlQ[`SCF_CTRL_RIE];

  always @(posedge sys_clk) begin
    if (rst) begin
      irqStatQ <= 4'h0;
      irqMaskQ <= 4'h0;
    end else begin
      irqStatQ <= (irqStatQ & ~(wrIrqS ? hwdata[3:0] : 4'h0)) | irqEvents;
      if (wrIrqM) begin
        irqMaskQ <= hwdata[3:0];
      end
    end
  end

  assign irq = |(irqStatQ & irqMaskQ);
endmodule // scf_serial_ctrl_status_flags

// [test/scf_flags_props.sv]
`timescale 1ns/10ps
module scf_flags_props #(
  parameter KEEP_IN_STANDBY = 1'b0
) (
  input wire        sys_clk,
  input wire        rst,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  input wire        hwStandby,
  input wire        swStandby,
  input wire        moduleStop,
  input wire        txLoad,
  input wire        dmaTxWrite,
  input wire [7:0]  dmaTxData,
  input wire        txEmptyIrq,
  input wire        rxRun,
  input wire        txRun,
  input wire        baudTick,
  input wire [7:0]  txHoldingReg,
  input wire        irq
);
  // accepted requests and the standby levels that clear control
  wire req   = hsel && htrans[1];
  wire wrReq = req && hwrite;
  wire stby  = hwStandby || (!KEEP_IN_STANDBY && (swStandby || moduleStop));
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_ready_high: assert property (hreadyout)
    else $error("wait state inserted");
  a_resp_okay: assert property (!hresp)
    else $error("error response seen");
  a_reset_quiet: assert property (
    $fell(rst) |-> !(txEmptyIrq || irq || rxRun || txRun) && baudTick
      && hrdata == 32'h0) else $error("outputs not at reset values");
  a_stby_clear: assert property (
    stby |-> ##2 !(txEmptyIrq || txRun || rxRun))
    else $error("standby left control set");
  a_dma_load: assert property (
    dmaTxWrite |=> txHoldingReg == $past(dmaTxData))
    else $error("dma data not in holding register");
  a_irq_rise: assert property (
    $rose(txEmptyIrq) |-> $past(txLoad) || $past(wrReq, 2))
    else $error("empty request rose without cause");
  a_irq_holds: assert property (
    !wrReq ##1 (txEmptyIrq && !wrReq && !dmaTxWrite && !stby)
      |=> txEmptyIrq) else $error("empty request dropped alone");
  a_rdata_holds: assert property (
    !(req && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
endmodule // scf_flags_props

bind scf_serial_ctrl_status_flags scf_flags_props #(
  .KEEP_IN_STANDBY(KEEP_IN_STANDBY)
) u_props (
  .sys_clk, .rst, .hsel, .htrans, .hwrite, .hreadyout, .hresp, .hrdata,
  .hwStandby, .swStandby, .moduleStop, .txLoad, .dmaTxWrite, .dmaTxData,
  .txEmptyIrq, .rxRun, .txRun, .baudTick, .txHoldingReg, .irq
);

// [test/scf_remote_station.sv]
`timescale 1ns/10ps
module scf_remote_station (
  input  wire        sys_clk,
  output logic       txLoad,
  output logic       txLastBit,
  output logic       rxDone,
  output logic [7:0] rxByte,
  output logic       rxParityBit,
  output logic       rxMpBit
);
  // lines idle at time zero
  initial begin
    {txLoad, txLastBit, rxDone, rxParityBit, rxMpBit} = 5'h0;
    rxByte = 8'hA5;
  end
  // one frame; lines turn over once the strobe is gone
  task frame(input logic [7:0] b, input logic p, input logic m);
    @(posedge sys_clk);
    {rxByte, rxParityBit, rxMpBit, rxDone} <= {b, p, m, 1'b1};
    @(posedge sys_clk);
    {rxByte, rxParityBit, rxMpBit, rxDone} <= {~b, ~p, ~m, 1'b0};
  endtask
  // shifter event: load from holding, or last bit sent
  task shift(input logic last);
    @(posedge sys_clk);
    {txLoad, txLastBit} <= {!last, last};
    @(posedge sys_clk);
    {txLoad, txLastBit} <= 2'h0;
  endtask
endmodule // scf_remote_station

// [test/scf_serial_ctrl_status_flags_tb.sv]
`timescale 1ns/10ps
module scf_serial_ctrl_status_flags_tb;
  logic        sys_clk, rst, hsel, hwrite, dmaTxWrite;
  logic        hwStandby, swStandby, moduleStop;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata;
  logic [7:0]  dmaTxData, rdv, cnt;
  wire         hreadyout, txLoad, txLastBit, rxDone, rxParityBit, rxMpBit;
  wire         txEmptyIrq, rxRun, txRun, baudTick, irq;
  wire [7:0]   rxByte, txHoldingReg;
  wire [31:0]  hrdata;
  int          nFail, nChecks;
  // design and remote station
  scf_serial_ctrl_status_flags DUT (
    .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .hwStandby,
    .swStandby, .moduleStop, .txLoad, .txLastBit, .rxDone, .rxByte,
    .rxParityBit, .rxMpBit, .dmaTxWrite, .dmaTxData, .txEmptyIrq, .rxRun,
    .txRun, .baudTick, .txHoldingReg, .irq
  );
  scf_remote_station rs (
    .sys_clk, .txLoad, .txLastBit, .rxDone, .rxByte, .rxParityBit, .rxMpBit
  );
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  // verdict and end of run
  task tally_and_finish;
    $display("checks %0d mismatches %0d", nChecks, nFail);
    if (nFail == 0 && nChecks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // compare seen against expected
  task chk(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      nFail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // next edge with hready high, bounded
  task edgeRdy;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        nFail++;
        tally_and_finish();
      end
      @(posedge sys_clk);
    end
  endtask
  // one single-word transfer; read data lands in rdv
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {haddr, hwrite, htrans} <= {24'h0, a, w, 2'h2};
    edgeRdy();
    {htrans, hwdata} <= {2'h0, 24'h0, d};
    edgeRdy();
    rdv = hrdata[7:0];
  endtask
  // let register updates land
  task settle;
    repeat (2) @(negedge sys_clk);
  endtask
  // reset values and an unmapped read
  task t_reset;
    chk({4'h0, irq, txEmptyIrq, rxRun, txRun}, 8'h00);
    xfer(1'b0, 8'h00, 8'h00);
    chk(rdv, 8'h00);
    xfer(1'b0, 8'h04, 8'h00);
    chk(rdv, 8'h84);
    xfer(1'b0, 8'h1C, 8'h00);
    chk(rdv, 8'h00);
  endtask
  // control read back, each standby input, enable clear
  task t_ctrl;
    int k;
    for (k = 0; k < 3; k++) begin
      xfer(1'b1, 8'h00, 8'hFF);
      xfer(1'b0, 8'h00, 8'h00);
      chk(rdv, 8'hFF);
      settle();
      chk({7'h0, txEmptyIrq}, 8'h01);
      @(posedge sys_clk);
      {hwStandby, swStandby, moduleStop} <= 3'h1 << k;
      @(posedge sys_clk);
      {hwStandby, swStandby, moduleStop} <= 3'h0;
      xfer(1'b0, 8'h00, 8'h00);
      chk(rdv, 8'h00);
    end
    xfer(1'b1, 8'h00, 8'hA0);
    xfer(1'b1, 8'h00, 8'h20);
    settle();
    chk({7'h0, txEmptyIrq}, 8'h00);
  endtask
  // empty and done flags through load, last bit, dma, enable off
  task t_txflags;
    xfer(1'b0, 8'h04, 8'h00);
    xfer(1'b1, 8'h04, 8'h04);
    xfer(1'b0, 8'h04, 8'h00);
    chk(rdv & 8'h84, 8'h00);
    xfer(1'b1, 8'h00, 8'hA0);
    settle();
    chk({7'h0, txEmptyIrq}, 8'h00);
    rs.shift(1'b0);
    settle();
    chk({7'h0, txEmptyIrq}, 8'h01);
    rs.shift(1'b1);
    xfer(1'b0, 8'h04, 8'h00);
    chk(rdv & 8'h84, 8'h84);
    @(posedge sys_clk);
    {dmaTxWrite, dmaTxData} <= {1'b1, 8'h5A};
    @(posedge sys_clk);
    dmaTxWrite <= 1'b0;
    xfer(1'b0, 8'h04, 8'h00);
    chk(rdv & 8'h04, 8'h00);
    xfer(1'b1, 8'h00, 8'h00);
    settle();
    xfer(1'b0, 8'h04, 8'h00);
    chk(rdv & 8'h04, 8'h04);
  endtask
  // even parity error: flag, stall, hold, clear
  task t_parity;
    xfer(1'b1, 8'h10, 8'h08);
    xfer(1'b1, 8'h08, 8'h20);
    xfer(1'b1, 8'h00, 8'h50);
    xfer(1'b1, 8'h04, 8'hFF);
    rs.frame(8'h01, 1'b0, 1'b0);
    settle();
    chk({4'h0, irq, 2'h0, rxRun}, 8'h08);
    xfer(1'b1, 8'h04, 8'h00);
    xfer(1'b1, 8'h00, 8'h00);
    xfer(1'b0, 8'h04, 8'h00);
    chk(rdv & 8'h48, 8'h08);
    xfer(1'b0, 8'h18, 8'h00);
    chk(rdv, 8'h01);
    xfer(1'b1, 8'h04, 8'h00);
    xfer(1'b0, 8'h04, 8'h00);
    chk(rdv & 8'h08, 8'h00);
  endtask
  // multiprocessor bit set, held with receive off, cleared
  task t_mp;
    xfer(1'b1, 8'h08, 8'h04);
    xfer(1'b1, 8'h00, 8'h10);
    rs.frame(8'h33, 1'b0, 1'b1);
    xfer(1'b1, 8'h00, 8'h00);
    xfer(1'b0, 8'h04, 8'h00);
    chk(rdv & 8'h02, 8'h02);
    xfer(1'b1, 8'h04, 8'h00);
    xfer(1'b1, 8'h00, 8'h10);
    rs.frame(8'h33, 1'b1, 1'b0);
    xfer(1'b0, 8'h04, 8'h00);
    chk(rdv & 8'h42, 8'h40);
  endtask
  // ticks in 64 cycles for each source select
  task t_baud;
    int m, i;
    for (m = 0; m < 4; m++) begin
      xfer(1'b1, 8'h08, m[7:0]);
      cnt = 8'h00;
      for (i = 0; i < 64; i++) begin
        @(negedge sys_clk);
        cnt += {7'h0, baudTick};
      end
      chk(cnt, 8'h40 >> (2 * m));
    end
  endtask
  // reset, then every scenario in turn
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    {hsel, hwrite, dmaTxWrite, hwStandby, swStandby, moduleStop} = 6'h20;
    {htrans, hsize, haddr, hwdata, dmaTxData} = {2'h0, 3'h2, 72'h0};
    nFail = 0;
    nChecks = 0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_txflags();
    t_parity();
    t_mp();
    t_baud();
    tally_and_finish();
  end
endmodule // scf_serial_ctrl_status_flags_tb
